// *** rtl/kwd_map.vh ***
// register map, field positions, keys and timing constants of the keyed watchdog
`ifndef KWD_MAP_VH
`define KWD_MAP_VH

// ****************************************************************
// bus and register placement
// ****************************************************************
`define KWD_ADDR_W        10
`define KWD_CTL_INDEX     10'h0e6
// byte address is four times the index
`define KWD_CTL_ADDR      10'h398
`define KWD_DATA_W        32
`define KWD_REG_W         16

// ****************************************************************
// control and status fields
// ****************************************************************
`define KWD_CTL_RESET     16'hc080
`define KWD_BIT_ON        15
`define KWD_BIT_RST_SEL   14
`define KWD_BIT_RST_SEEN  13
`define KWD_BIT_INT_SEEN  12
`define KWD_BIT_TEST      11
`define KWD_FIELD_HI      7
`define KWD_FIELD_LO      0
`define KWD_FIELD_W       8
`define KWD_FIELD_RESET   8'h80

// ****************************************************************
// key words
// ****************************************************************
`define KWD_KEY_UNLOCK_A  16'h3333
`define KWD_KEY_UNLOCK_B  16'hcccc
`define KWD_KEY_RESTART_A 16'haaaa
`define KWD_KEY_RESTART_B 16'h5555

// ****************************************************************
// interval timing, in processor clocks as powers of two
// ****************************************************************
`define KWD_CNT_W         27
`define KWD_EXP_BIT0      10
`define KWD_EXP_BASE      19
`define KWD_EXP_TEST      4

`endif

// *** rtl/kwd_interval.v ***
// interval field decode: lowest set bit picks the terminal count
`timescale 1ns/1ns
`include "kwd_map.vh"

module kwd_interval
#(
	parameter integer EXP_REDUCE = 0
)
(
	input  wire [`KWD_FIELD_W-1:0] interval_field,
	input  wire                    test_mode,
	output reg  [`KWD_CNT_W-1:0]   terminal,
	output reg                     terminal_valid
);

	integer i;
	integer exponent;

	// ****************************************************************
	// priority decode, lowest bit wins
	// ****************************************************************
	always @*
	begin
		exponent       = 0;
		terminal_valid = 1'b0;
		for (i = `KWD_FIELD_W - 1; i >= 0; i = i - 1)
		begin
			if (interval_field[i])
			begin
				terminal_valid = 1'b1;
				exponent = (i == 0) ? `KWD_EXP_BIT0 : (`KWD_EXP_BASE + i);
			end
		end
		exponent = exponent - EXP_REDUCE;
		if (test_mode)
			exponent = `KWD_EXP_TEST;
		if (exponent < 1)
			exponent = 1;
		terminal = ({{(`KWD_CNT_W-1){1'b0}}, 1'b1} << exponent) - {{(`KWD_CNT_W-1){1'b0}}, 1'b1};
	end

endmodule

// *** rtl/kwd_count.v ***
// hidden timeout counter with restart and expiry detect
`timescale 1ns/1ns
`include "kwd_map.vh"

module kwd_count
(
	input  wire                  ref_clk,
	input  wire                  rst,
	input  wire                  ce,
	input  wire                  run,
	input  wire                  restart,
	input  wire [`KWD_CNT_W-1:0] terminal,
	input  wire                  terminal_valid,
	output wire                  expire
);

	reg  [`KWD_CNT_W-1:0] count_reg;

	// ****************************************************************
	// expiry, also immediate when the interval shrank below the count
	// ****************************************************************
	assign expire = run & terminal_valid & (count_reg >= terminal);

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			count_reg <= {`KWD_CNT_W{1'b0}};
		else if (ce)
		begin
			if (restart || expire)
				count_reg <= {`KWD_CNT_W{1'b0}};
			else if (run)
				count_reg <= count_reg + {{(`KWD_CNT_W-1){1'b0}}, 1'b1};
		end
	end

endmodule

// *** rtl/kwd_watchdog.v ***
// keyed watchdog timer with avalon-mm control and status register
`timescale 1ns/1ns
`include "kwd_map.vh"

module kwd_watchdog
#(
	parameter integer EXP_REDUCE = 0
)
(
	input  wire                    ref_clk,
	input  wire                    rst,
	input  wire                    por,
	input  wire                    ce,
	input  wire [`KWD_ADDR_W-1:0]  avs_address,
	input  wire                    avs_read,
	input  wire                    avs_write,
	input  wire [`KWD_DATA_W-1:0]  avs_writedata,
	input  wire [3:0]              avs_byteenable,
	output wire [`KWD_DATA_W-1:0]  avs_readdata,
	output wire                    avs_waitrequest,
	output wire                    sys_reset_req,
	output wire                    nmi_req
);

	// ****************************************************************
	// key recognition states
	// ****************************************************************
	localparam [1:0] KEY_IDLE     = 2'b00;
	localparam [1:0] KEY_UNLOCK_A = 2'b01;
	localparam [1:0] KEY_OPEN     = 2'b10;
	localparam [1:0] KEY_RESTART  = 2'b11;

	// ****************************************************************
	// declarations
	// ****************************************************************
	reg  [1:0]                key_state_reg;
	reg  [1:0]                key_state_next;
	reg                       ack_reg;
	reg  [`KWD_DATA_W-1:0]    readdata_reg;
	reg                       timer_on_reg;
	reg                       reset_on_expiry_reg;
	reg                       expiry_reset_seen_reg;
	reg                       expiry_interrupt_seen_reg;
	reg                       test_mode_reg;
	reg  [`KWD_FIELD_W-1:0]   interval_reg;
	reg                       config_done_reg;
	reg                       sys_reset_req_reg;
	reg                       nmi_req_reg;
	reg                       cause_reg;
	reg                       started_a_reg;
	reg                       started_b_reg;
	reg                       restart_pulse;
	reg                       config_write;
	reg                       keyed_write;
	wire                      busy;
	reg                       hit;
	wire                      full_word;
	wire                      do_write;
	wire                      do_read;
	wire [`KWD_REG_W-1:0]     wdata;
	wire [`KWD_REG_W-1:0]     status_word;
	wire [`KWD_CNT_W-1:0]     terminal;
	wire                      terminal_valid;
	wire                      expire;
	wire                      run;
	wire                      expire_to_reset;
	wire                      expire_to_int;
	wire                      keyed_read;
	wire                      capture;
	wire                      req_any;
	wire                      is_unlock_a;
	wire                      is_unlock_b;
	wire                      is_restart_a;
	wire                      is_restart_b;
	wire                      wr_on;
	wire                      wr_rst_sel;
	wire                      wr_test;
	wire [`KWD_FIELD_W-1:0]   wr_interval;

	// ****************************************************************
	// avalon-mm slave: one wait cycle, then the access completes
	// ****************************************************************
	assign req_any         = avs_read | avs_write;
	assign busy            = req_any & ce;
	// a frozen clock enable keeps the master waiting
	assign avs_waitrequest = req_any & ~(ack_reg & ce);
	assign full_word       = (avs_byteenable[1:0] == 2'b11);
	assign do_write        = busy & ack_reg & avs_write & hit & full_word;
	assign do_read         = busy & ack_reg & avs_read & hit;
	assign wdata           = avs_writedata[`KWD_REG_W-1:0];
	assign avs_readdata    = readdata_reg;

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			ack_reg <= 1'b0;
		else if (ce)
			ack_reg <= busy & ~ack_reg;
	end

	// ****************************************************************
	// address decode, only the control word is mapped
	// ****************************************************************
	always @*
	begin
		if (avs_address == `KWD_CTL_ADDR)
			hit = 1'b1;
		else
			hit = 1'b0;
	end

	// ****************************************************************
	// status word, the count itself never appears here
	// ****************************************************************
	assign status_word = {timer_on_reg, reset_on_expiry_reg, expiry_reset_seen_reg,
		expiry_interrupt_seen_reg, test_mode_reg, 3'b000, interval_reg};

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			readdata_reg <= {`KWD_DATA_W{1'b0}};
		else if (ce && busy && !ack_reg && avs_read)
		begin
			if (hit)
				readdata_reg <= {{(`KWD_DATA_W-`KWD_REG_W){1'b0}}, status_word};
			else
				readdata_reg <= {`KWD_DATA_W{1'b0}};
		end
	end

	// ****************************************************************
	// write word classification
	// ****************************************************************
	assign is_unlock_a  = (wdata == `KWD_KEY_UNLOCK_A);
	assign is_unlock_b  = (wdata == `KWD_KEY_UNLOCK_B);
	assign is_restart_a = (wdata == `KWD_KEY_RESTART_A);
	assign is_restart_b = (wdata == `KWD_KEY_RESTART_B);
	assign wr_on        = wdata[`KWD_BIT_ON];
	assign wr_rst_sel   = wdata[`KWD_BIT_RST_SEL];
	assign wr_test      = wdata[`KWD_BIT_TEST];
	assign wr_interval  = wdata[`KWD_FIELD_HI:`KWD_FIELD_LO];

	// ****************************************************************
	// key sequence recognition
	// ****************************************************************
	always @*
	begin
		key_state_next = key_state_reg;
		restart_pulse  = 1'b0;
		config_write   = 1'b0;
		keyed_write    = 1'b0;
		if (do_write)
		begin
			case (key_state_reg)
				KEY_OPEN:
				begin
					key_state_next = KEY_IDLE;
					config_write   = ~config_done_reg;
					keyed_write    = 1'b1;
				end
				default:
				begin
					if (key_state_reg == KEY_UNLOCK_A && is_unlock_b)
						key_state_next = KEY_OPEN;
					else if (key_state_reg == KEY_RESTART && is_restart_b)
					begin
						key_state_next = KEY_IDLE;
						restart_pulse  = 1'b1;
						keyed_write    = 1'b1;
					end
					else if (is_unlock_a)
						key_state_next = KEY_UNLOCK_A;
					else if (is_restart_a)
						key_state_next = KEY_RESTART;
					else
						key_state_next = KEY_IDLE;
				end
			endcase
		end
	end

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			key_state_reg <= KEY_IDLE;
		else if (ce)
			key_state_reg <= key_state_next;
	end

	assign keyed_read = do_read & (key_state_reg == KEY_OPEN);

	// ****************************************************************
	// configuration, accepted once per reset
	// ****************************************************************
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			timer_on_reg        <= 1'b1;
			reset_on_expiry_reg <= 1'b1;
			test_mode_reg       <= 1'b0;
			interval_reg        <= `KWD_FIELD_RESET;
			config_done_reg     <= 1'b0;
		end
		else if (ce && config_write)
		begin
			timer_on_reg        <= wr_on;
			reset_on_expiry_reg <= wr_rst_sel;
			test_mode_reg       <= wr_test;
			interval_reg        <= wr_interval;
			config_done_reg     <= 1'b1;
		end
	end

	// ****************************************************************
	// interval decode and counter
	// ****************************************************************
	kwd_interval
	#(
		.EXP_REDUCE     (EXP_REDUCE)
	)
	u_interval
	(
		.interval_field (interval_reg),
		.test_mode      (test_mode_reg),
		.terminal       (terminal),
		.terminal_valid (terminal_valid)
	);

	assign run = timer_on_reg & ~sys_reset_req_reg;

	kwd_count u_count
	(
		.ref_clk        (ref_clk),
		.rst            (rst),
		.ce             (ce),
		.run            (run),
		.restart        (restart_pulse),
		.terminal       (terminal),
		.terminal_valid (terminal_valid),
		.expire         (expire)
	);

	// ****************************************************************
	// expiry action
	// ****************************************************************
	assign expire_to_reset = expire & (reset_on_expiry_reg | expiry_interrupt_seen_reg);
	assign expire_to_int   = expire & ~reset_on_expiry_reg & ~expiry_interrupt_seen_reg;

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			sys_reset_req_reg <= 1'b0;
			nmi_req_reg       <= 1'b0;
		end
		else if (ce)
		begin
			if (expire_to_reset)
				sys_reset_req_reg <= 1'b1;
			nmi_req_reg <= expire_to_int;
		end
	end

	assign sys_reset_req = sys_reset_req_reg;
	assign nmi_req       = nmi_req_reg;

	// ****************************************************************
	// interrupt-event flag, set wins over clear
	// ****************************************************************
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			expiry_interrupt_seen_reg <= 1'b0;
		else if (ce)
		begin
			if (expire_to_int)
				expiry_interrupt_seen_reg <= 1'b1;
			else if (keyed_write)
				expiry_interrupt_seen_reg <= 1'b0;
		end
	end

	// ****************************************************************
	// reset cause, kept across system reset by power-on reset only
	// ****************************************************************
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			started_a_reg <= 1'b0;
			started_b_reg <= 1'b0;
		end
		else if (ce)
		begin
			started_a_reg <= 1'b1;
			started_b_reg <= started_a_reg;
		end
	end

	assign capture = ce & started_a_reg & ~started_b_reg;

	always @(posedge ref_clk or posedge por)
	begin
		if (por)
			cause_reg <= 1'b0;
		else if (ce)
		begin
			if (expire_to_reset)
				cause_reg <= 1'b1;
			else if (capture)
				cause_reg <= 1'b0;
		end
	end

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			expiry_reset_seen_reg <= 1'b0;
		else if (ce)
		begin
			if (capture)
				expiry_reset_seen_reg <= cause_reg;
			else if (keyed_write || keyed_read)
				expiry_reset_seen_reg <= 1'b0;
		end
	end

endmodule

// *** test/kwd_watchdog_chk.sv ***
// concurrent checks on the keyed watchdog ports
`timescale 1ns/1ns
`include "kwd_map.vh"

module kwd_watchdog_chk
(
	input wire                   ref_clk,
	input wire                   rst,
	input wire                   por,
	input wire                   ce,
	input wire [`KWD_ADDR_W-1:0] avs_address,
	input wire                   avs_read,
	input wire                   avs_write,
	input wire [`KWD_DATA_W-1:0] avs_writedata,
	input wire [3:0]             avs_byteenable,
	input wire [`KWD_DATA_W-1:0] avs_readdata,
	input wire                   avs_waitrequest,
	input wire                   sys_reset_req,
	input wire                   nmi_req
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence req_held;
		ce && (avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence req_done;
		(avs_read || avs_write) && !avs_waitrequest;
	endsequence
	sequence rd_done;
		avs_read && !avs_waitrequest;
	endsequence
	one_wait_a: assert property (req_held |=> !avs_waitrequest) else $error("no answer after one wait");
	idle_free_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("wait while idle");
	rewait_a: assert property (req_done ##1 (avs_read || avs_write) |-> avs_waitrequest) else $error("no wait");
	upper_zero_a: assert property (rd_done |-> avs_readdata[31:16] == 16'h0000) else $error("upper bits set");
	reserved_zero_a: assert property (rd_done and avs_address == `KWD_CTL_ADDR |-> avs_readdata[10:8] == 3'h0)
		else $error("reserved bits set");
	unmapped_zero_a: assert property (rd_done and avs_address != `KWD_CTL_ADDR |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	reset_hold_a: assert property (sys_reset_req |=> sys_reset_req) else $error("reset request dropped");
	nmi_pulse_a: assert property (nmi_req |=> !nmi_req) else $error("interrupt longer than one cycle");
	nmi_only_a: assert property (nmi_req |-> !sys_reset_req) else $error("interrupt with reset request");
endmodule

bind kwd_watchdog kwd_watchdog_chk u_chk (.ref_clk(ref_clk), .rst(rst), .por(por), .ce(ce),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.sys_reset_req(sys_reset_req), .nmi_req(nmi_req));

// *** test/tb_top.sv ***
// self-checking bench of the keyed watchdog
`timescale 1ns/1ns
`include "kwd_map.vh"

module tb_top;
	localparam [`KWD_ADDR_W-1:0] RA = `KWD_CTL_ADDR;
	localparam [`KWD_ADDR_W-1:0] UA = 10'h004;
	logic                   ref_clk;
	logic                   rst;
	logic                   por;
	logic                   ce;
	logic [`KWD_ADDR_W-1:0] avs_address;
	logic                   avs_read;
	logic                   avs_write;
	logic [`KWD_DATA_W-1:0] avs_writedata;
	logic [`KWD_DATA_W-1:0] avs_readdata;
	logic                   avs_waitrequest;
	logic                   sys_reset_req;
	logic                   nmi_req;
	integer                 n_mismatch;
	integer                 check_count;
	logic [31:0]            rd;
	integer                 n;

	kwd_watchdog #(.EXP_REDUCE(16)) u_dut (.ref_clk(ref_clk), .rst(rst), .por(por), .ce(ce),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.sys_reset_req(sys_reset_req), .nmi_req(nmi_req));

	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task close_out;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count = check_count + 1;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			n_mismatch = n_mismatch + 1;
		end
	endtask

	task bus_go(input logic wr, input logic [`KWD_ADDR_W-1:0] a, input logic [15:0] d, output logic [31:0] q);
		integer i;
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_read <= ~wr;
		avs_write <= wr;
		i = 0;
		do
		begin
			@(posedge ref_clk);
			i = i + 1;
		end
		while (avs_waitrequest !== 1'b0 && i < 50);
		if (i >= 50)
		begin
			chk("waitrequest timeout", 32'h0, 32'h1);
			close_out;
		end
		q = avs_readdata;
	endtask

	task bus(input logic wr, input logic [`KWD_ADDR_W-1:0] a, input logic [15:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		bus_go(wr, a, d, q);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task wr(input logic [`KWD_ADDR_W-1:0] a, input logic [15:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	// cycles until reset request (sel 0) or interrupt (sel 1); max+1 on timeout
	task wait_evt(input logic sel, input integer max, output integer cnt);
		cnt = 0;
		do
		begin
			@(negedge ref_clk);
			cnt = cnt + 1;
		end
		while ((sel ? nmi_req : sys_reset_req) !== 1'b1 && cnt <= max);
	endtask

	task do_reset;
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task t_reset_values;
		bus(1'b0, RA, 16'h0, rd);
		chk("reset value", 32'h0000c080, rd);
		bus(1'b0, UA, 16'h0, rd);
		chk("unmapped read", 32'h0, rd);
		@(posedge ref_clk);
		ce <= 1'b0;
		repeat (100) @(posedge ref_clk);
		ce <= 1'b1;
		wait_evt(1'b0, 1100, n);
		chk("default expiry time", 1, n >= 1000 && n <= 1100);
		do_reset;
		bus(1'b0, RA, 16'h0, rd);
		chk("value after expiry reset", 32'h0000e080, rd);
		$display("test reset values done");
	endtask

	task t_nmi_then_reset;
		wr(RA, `KWD_KEY_RESTART_A);
		wr(RA, `KWD_KEY_RESTART_B);
		wr(RA, `KWD_KEY_UNLOCK_A);
		wr(UA, 16'h1234);
		bus(1'b0, UA, 16'h0, rd);
		wr(RA, `KWD_KEY_UNLOCK_B);
		wr(RA, 16'h80f4);
		wait_evt(1'b1, 40, n);
		chk("interrupt raised", 1, n <= 40);
		chk("no reset on interrupt", 32'h0, sys_reset_req);
		wait_evt(1'b0, 40, n);
		chk("lowest bit interval", 1, n >= 30 && n <= 34);
		bus(1'b0, RA, 16'h0, rd);
		chk("flag after interrupt", 32'h000090f4, rd);
		chk("reset with flag set", 32'h1, sys_reset_req);
		do_reset;
		$display("test interrupt then reset done");
	endtask

	task t_restart_once;
		wr(RA, `KWD_KEY_UNLOCK_A);
		wr(RA, `KWD_KEY_UNLOCK_B);
		wr(RA, 16'hc004);
		repeat (10)
		begin
			wr(RA, `KWD_KEY_RESTART_A);
			wr(UA, 16'h0);
			wr(RA, `KWD_KEY_RESTART_B);
		end
		@(posedge ref_clk);
		bus_go(1'b1, RA, `KWD_KEY_RESTART_A, rd);
		bus_go(1'b1, RA, `KWD_KEY_RESTART_B, rd);
		avs_write <= 1'b0;
		chk("restart holds off expiry", 32'h0, sys_reset_req);
		wr(RA, `KWD_KEY_UNLOCK_A);
		wr(RA, `KWD_KEY_UNLOCK_B);
		wr(RA, 16'h8080);
		wr(RA, 16'h0000);
		bus(1'b0, RA, 16'h0, rd);
		chk("second configuration ignored", 32'h0000c004, rd);
		wait_evt(1'b0, 40, n);
		chk("short interval reset", 1, n >= 15 && n <= 19);
		do_reset;
		$display("test restart and single configuration done");
	endtask

	task t_zero_interval;
		wr(RA, `KWD_KEY_UNLOCK_A);
		wr(RA, `KWD_KEY_UNLOCK_B);
		wr(RA, 16'hc000);
		wait_evt(1'b0, 1200, n);
		chk("zero interval no expiry", 32'h0, sys_reset_req);
		chk("zero interval no interrupt", 32'h0, nmi_req);
		$display("test zero interval done");
	endtask

	initial
	begin
		n_mismatch = 0;
		check_count = 0;
		rst = 1'b1;
		por = 1'b1;
		ce = 1'b1;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		por <= 1'b0;
		repeat (3) @(posedge ref_clk);
		t_reset_values;
		t_nmi_then_reset;
		t_restart_once;
		t_zero_interval;
		close_out;
	end
endmodule
